/* rtl/pte_cfg.svh */
`ifndef PTE_CFG_SVH
`define PTE_CFG_SVH

// Global register byte addresses
`define PTE_ENABLE_OFS    10'h000
`define PTE_START_OFS     10'h004
`define PTE_STATUS_OFS    10'h008
`define PTE_PINSEL_OFS    10'h00c

// Channel window: address[9:8] selects it, [7:4] the channel, [3:2] the register
`define PTE_CH_WIN_SEL    2'h1
`define PTE_CH_CFG_IDX    2'h0
`define PTE_CH_PAT_IDX    2'h1
`define PTE_CH_LOOPS_IDX  2'h2
`define PTE_CH_RSTRT_IDX  2'h3

// Field positions
`define PTE_CFG_MODE_LSB  0
`define PTE_CFG_DIV_LSB   4
`define PTE_CFG_LAST_LSB  8
`define PTE_PINSEL_FN_LSB 16

// Reset values
`define PTE_RST_MODE      2'h0
`define PTE_RST_DIV       4'h0
`define PTE_RST_LAST      5'h1f
`define PTE_RST_PATTERN   32'h0000_0000
`define PTE_RST_LOOPS     16'h0001
`define PTE_RST_WORD16    16'h0000
`define PTE_MIN_LAST      5'h01

`endif

/* rtl/pte_pkg.sv */
package pte_pkg;

    // Output behaviour of one generator
    typedef enum logic [1:0] {
        PTE_SINGLE = 2'b00,
        PTE_REPEAT = 2'b01,
        PTE_SQUARE = 2'b10
    } pte_mode_e;

    // Generator sequencer states, one-hot
    typedef enum logic [1:0] {
        PTE_IDLE = 2'b01,
        PTE_RUN  = 2'b10
    } pte_state_e;

    // Per-generator configuration
    typedef struct packed {
        pte_mode_e   mode;
        logic [3:0]  divExp;
        logic [4:0]  lastIdx;
        logic [31:0] pattern;
        logic [15:0] loops;
    } pte_cfg_s;

endpackage : pte_pkg

/* rtl/pte_channel.sv */
`include "pte_cfg.svh"

module pte_channel #(
    parameter int DIVW = 16
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // Control
    input  wire logic              chEnable,
    input  wire logic              chStart,
    input  wire pte_pkg::pte_cfg_s chCfg,
    // Results
    output logic                   pulseOut,
    output logic                   running,
    output logic                   loopDone
);

    pte_pkg::pte_state_e state_ff, nxt_state;
    logic [DIVW-1:0]     divCnt_ff, nxt_divCnt;
    logic [4:0]          bitIdx_ff, nxt_bitIdx;
    logic [15:0]         loopCnt_ff, nxt_loopCnt;
    logic                out_ff, nxt_out;
    logic                done_ff, nxt_done;
    logic [DIVW:0]       divMask;
    logic                tick;
    logic [4:0]          idxNext;
    logic                finish;

    // Divide by 2^(divExp+1): the counter wraps at an all-ones mask
    assign divMask = ((DIVW+1)'(1) << ({1'b0, chCfg.divExp} + 5'h01)) - (DIVW+1)'(1);
    assign tick    = divCnt_ff == divMask[DIVW-1:0];
    assign idxNext = bitIdx_ff + 5'h01;
    assign finish  = (chCfg.mode == pte_pkg::PTE_SINGLE) ||
                     (chCfg.loops != 16'h0000 && (loopCnt_ff + 16'h0001) == chCfg.loops);

    // Sequencer next state; start wins over a finish in the same cycle
    always_comb begin
        nxt_state   = state_ff;
        nxt_divCnt  = divCnt_ff;
        nxt_bitIdx  = bitIdx_ff;
        nxt_loopCnt = loopCnt_ff;
        nxt_out     = out_ff;
        nxt_done    = 1'b0;
        if (!chEnable) begin
            nxt_state  = pte_pkg::PTE_IDLE;
            nxt_divCnt = '0;
            nxt_out    = 1'b0;
        end else if (chStart) begin
            nxt_state   = pte_pkg::PTE_RUN;
            nxt_divCnt  = '0;
            nxt_bitIdx  = 5'h00;
            nxt_loopCnt = 16'h0000;
            nxt_out     = (chCfg.mode == pte_pkg::PTE_SQUARE) ? 1'b1 : chCfg.pattern[0];
        end else begin
            case (state_ff)
                pte_pkg::PTE_IDLE: begin
                    nxt_out = 1'b0;
                end
                pte_pkg::PTE_RUN: begin
                    nxt_divCnt = tick ? '0 : divCnt_ff + DIVW'(1);
                    if (tick) begin
                        if (chCfg.mode == pte_pkg::PTE_SQUARE) begin
                            if (bitIdx_ff >= chCfg.lastIdx) begin
                                nxt_bitIdx = 5'h00;
                                nxt_out    = ~out_ff;
                            end else begin
                                nxt_bitIdx = idxNext;
                            end
                        end else if (bitIdx_ff >= chCfg.lastIdx) begin
                            if (finish) begin
                                nxt_state = pte_pkg::PTE_IDLE;
                                nxt_out   = 1'b0;
                                nxt_done  = 1'b1;
                            end else begin
                                nxt_bitIdx  = 5'h00;
                                nxt_loopCnt = loopCnt_ff + 16'h0001;
                                nxt_out     = chCfg.pattern[0];
                            end
                        end else begin
                            nxt_bitIdx = idxNext;
                            nxt_out    = chCfg.pattern[idxNext];
                        end
                    end
                end
                default: begin
                    nxt_state = pte_pkg::PTE_IDLE;
                    nxt_out   = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= pte_pkg::PTE_IDLE;
            divCnt_ff  <= '0;
            bitIdx_ff  <= 5'h00;
            loopCnt_ff <= 16'h0000;
            out_ff     <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            divCnt_ff  <= nxt_divCnt;
            bitIdx_ff  <= nxt_bitIdx;
            loopCnt_ff <= nxt_loopCnt;
            out_ff     <= nxt_out;
            done_ff    <= nxt_done;
        end
    end

    assign pulseOut = out_ff;
    assign running  = state_ff == pte_pkg::PTE_RUN;
    assign loopDone = done_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic quiet;
    assign quiet = chEnable && !chStart;

    a_disabled_low: assert property (!chEnable |=> !pulseOut ##1 !pulseOut || !$past(chEnable))
        else $error("disabled generator output not low");
    a_start_runs: assert property (chEnable && chStart |=> running && divCnt_ff == '0)
        else $error("start did not launch the generator");
    a_div_two: assert property (running && quiet && chCfg.divExp == 4'h0 && tick |=> !tick)
        else $error("divide by two ticked on adjacent cycles");
    a_single_stop: assert property (running && quiet && tick && chCfg.mode == pte_pkg::PTE_SINGLE &&
                                    bitIdx_ff >= chCfg.lastIdx |=> !running && loopDone ##1 !loopDone)
        else $error("single shot did not stop after one pass");
    a_unlimited_runs: assert property (running && quiet && chCfg.mode == pte_pkg::PTE_REPEAT &&
                                       chCfg.loops == 16'h0000 |=> running)
        else $error("unlimited repeat stopped");
    a_pattern_bit: assert property (running && quiet && tick && chCfg.mode != pte_pkg::PTE_SQUARE &&
                                    bitIdx_ff < chCfg.lastIdx |=> pulseOut == $past(chCfg.pattern[idxNext]))
        else $error("pattern bit out of order");
    a_square_toggle: assert property (running && quiet && tick && chCfg.mode == pte_pkg::PTE_SQUARE &&
                                      bitIdx_ff >= chCfg.lastIdx |=> pulseOut != $past(pulseOut))
        else $error("square wave did not toggle at half period");

    c_single_done: cover property (running && chCfg.mode == pte_pkg::PTE_SINGLE ##1 loopDone);
    c_square_edge: cover property (running && chCfg.mode == pte_pkg::PTE_SQUARE ##1 $fell(pulseOut));

endmodule : pte_channel

/* rtl/pte_pin_route.sv */
module pte_pin_route #(
    parameter int NCH = 16
) (
    // Clock and reset
    input  wire logic           ref_clk,
    input  wire logic           resetn,
    // Generator outputs and selection
    input  wire logic [NCH-1:0] chOut,
    input  wire logic [NCH-1:0] altSel,
    input  wire logic [NCH-1:0] funcEn,
    // Pin positions, output only
    output logic [NCH-1:0]      pinAOut,
    output logic [NCH-1:0]      pinAEn,
    output logic [NCH-1:0]      pinBOut,
    output logic [NCH-1:0]      pinBEn
);

    logic [NCH-1:0] aOut_ff, aEn_ff, bOut_ff, bEn_ff;
    logic [NCH-1:0] nxt_aOut, nxt_aEn, nxt_bOut, nxt_bEn;

    // Route each output to its primary or alternative position
    always_comb begin
        nxt_aEn  = funcEn & ~altSel;
        nxt_bEn  = funcEn & altSel;
        nxt_aOut = chOut & nxt_aEn;
        nxt_bOut = chOut & nxt_bEn;
    end

    // Registered so the pins never see decode glitches
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aOut_ff <= '0;
            aEn_ff  <= '0;
            bOut_ff <= '0;
            bEn_ff  <= '0;
        end else begin
            aOut_ff <= nxt_aOut;
            aEn_ff  <= nxt_aEn;
            bOut_ff <= nxt_bOut;
            bEn_ff  <= nxt_bEn;
        end
    end

    assign pinAOut = aOut_ff;
    assign pinAEn  = aEn_ff;
    assign pinBOut = bOut_ff;
    assign pinBEn  = bEn_ff;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_route_enable: assert property (1'b1 |=> pinAEn == $past(funcEn & ~altSel) &&
                                     pinBEn == $past(funcEn & altSel) && (pinAEn & pinBEn) == '0)
        else $error("pin function enables wrong");
    a_route_value: assert property (1'b1 |=> pinBOut == $past(chOut & funcEn & altSel) &&
                                    pinAOut == $past(chOut & funcEn & ~altSel))
        else $error("generator output on wrong pin");

endmodule : pte_pin_route

/* rtl/pulse_train_engine.sv */
// Overview of operation
// - Sixteen generators, square or 2-32 bit pattern
// - Separate configuration and enable per generator
// - Start one generator or an aligned group
// - Rate set by per-generator power-of-two divider
// - Single shot plays pattern once, then stops
// - Repeat counted loops, or forever when zero
// - Loop count end restarts selected generators
// - Each output routable to an alternative pin
// - Outputs are output-only pin functions
`include "pte_cfg.svh"

module pulse_train_engine #(
    parameter int NCH  = 16,
    parameter int DIVW = 16
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    // Register port
    input  wire logic [9:0]       regAddr,
    input  wire logic [31:0]      regWdata,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [31:0]      regRdata,
    // Primary pin position
    output logic      [NCH-1:0]   pinAOut,
    output logic      [NCH-1:0]   pinAEn,
    // Alternative pin position
    output logic      [NCH-1:0]   pinBOut,
    output logic      [NCH-1:0]   pinBEn
);

    pte_pkg::pte_cfg_s cfg_ff     [NCH];
    pte_pkg::pte_cfg_s nxt_cfg    [NCH];
    logic [15:0]       restart_ff [NCH];
    logic [15:0]       nxt_restart[NCH];
    logic [15:0]       enable_ff, nxt_enable;
    logic [15:0]       altSel_ff, nxt_altSel;
    logic [15:0]       funcEn_ff, nxt_funcEn;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [15:0]       startWr;
    logic [NCH-1:0]    startVec;
    logic [NCH-1:0]    chOut;
    logic [NCH-1:0]    runVec;
    logic [NCH-1:0]    doneVec;
    logic              chWin;
    logic [3:0]        chSel;
    logic [1:0]        chReg;
    logic [4:0]        lastWr;

    assign chWin  = regAddr[9:8] == `PTE_CH_WIN_SEL && regAddr[1:0] == 2'h0;
    assign chSel  = regAddr[7:4];
    assign chReg  = regAddr[3:2];
    // A pattern shorter than two bits is not allowed; clamp it up
    assign lastWr = (regWdata[`PTE_CFG_LAST_LSB +: 5] < `PTE_MIN_LAST) ? `PTE_MIN_LAST
                                                                        : regWdata[`PTE_CFG_LAST_LSB +: 5];
    // One write to the start word launches every selected, enabled generator on one edge
    assign startWr = (regWr && regAddr == `PTE_START_OFS) ? regWdata[15:0] : 16'h0000;

    // Register writes and read data
    always_comb begin
        nxt_enable = enable_ff;
        nxt_altSel = altSel_ff;
        nxt_funcEn = funcEn_ff;
        for (int i = 0; i < NCH; i++) begin
            nxt_cfg[i]     = cfg_ff[i];
            nxt_restart[i] = restart_ff[i];
        end
        if (regWr) begin
            if (regAddr == `PTE_ENABLE_OFS) begin
                nxt_enable = regWdata[15:0];
            end else if (regAddr == `PTE_PINSEL_OFS) begin
                nxt_altSel = regWdata[15:0];
                nxt_funcEn = regWdata[`PTE_PINSEL_FN_LSB +: 16];
            end else if (chWin) begin
                case (chReg)
                    `PTE_CH_CFG_IDX: begin
                        nxt_cfg[chSel].mode    = pte_pkg::pte_mode_e'(regWdata[`PTE_CFG_MODE_LSB +: 2]);
                        nxt_cfg[chSel].divExp  = regWdata[`PTE_CFG_DIV_LSB +: 4];
                        nxt_cfg[chSel].lastIdx = lastWr;
                    end
                    `PTE_CH_PAT_IDX: begin
                        nxt_cfg[chSel].pattern = regWdata;
                    end
                    `PTE_CH_LOOPS_IDX: begin
                        nxt_cfg[chSel].loops = regWdata[15:0];
                    end
                    `PTE_CH_RSTRT_IDX: begin
                        nxt_restart[chSel] = regWdata[15:0];
                    end
                    default: begin
                        nxt_restart[chSel] = restart_ff[chSel];
                    end
                endcase
            end
        end
        nxt_rdata = 32'h0000_0000;
        if (regRd) begin
            if (regAddr == `PTE_ENABLE_OFS) begin
                nxt_rdata = {16'h0000, enable_ff};
            end else if (regAddr == `PTE_STATUS_OFS) begin
                nxt_rdata = {16'h0000, 16'(runVec)};
            end else if (regAddr == `PTE_PINSEL_OFS) begin
                nxt_rdata = {funcEn_ff, altSel_ff};
            end else if (chWin) begin
                case (chReg)
                    `PTE_CH_CFG_IDX:   nxt_rdata = {19'h00000, cfg_ff[chSel].lastIdx, cfg_ff[chSel].divExp,
                                                    2'h0, cfg_ff[chSel].mode};
                    `PTE_CH_PAT_IDX:   nxt_rdata = cfg_ff[chSel].pattern;
                    `PTE_CH_LOOPS_IDX: nxt_rdata = {16'h0000, cfg_ff[chSel].loops};
                    `PTE_CH_RSTRT_IDX: nxt_rdata = {16'h0000, restart_ff[chSel]};
                    default:           nxt_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // Register state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enable_ff <= `PTE_RST_WORD16;
            altSel_ff <= `PTE_RST_WORD16;
            funcEn_ff <= `PTE_RST_WORD16;
            rdata_ff  <= 32'h0000_0000;
            for (int i = 0; i < NCH; i++) begin
                cfg_ff[i].mode    <= pte_pkg::pte_mode_e'(`PTE_RST_MODE);
                cfg_ff[i].divExp  <= `PTE_RST_DIV;
                cfg_ff[i].lastIdx <= `PTE_RST_LAST;
                cfg_ff[i].pattern <= `PTE_RST_PATTERN;
                cfg_ff[i].loops   <= `PTE_RST_LOOPS;
                restart_ff[i]     <= `PTE_RST_WORD16;
            end
        end else begin
            enable_ff <= nxt_enable;
            altSel_ff <= nxt_altSel;
            funcEn_ff <= nxt_funcEn;
            rdata_ff  <= nxt_rdata;
            for (int i = 0; i < NCH; i++) begin
                cfg_ff[i]     <= nxt_cfg[i];
                restart_ff[i] <= nxt_restart[i];
            end
        end
    end

    assign regRdata = rdata_ff;

    // One generator per channel; start comes from software or a finished peer
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic [NCH-1:0] peerHit;
        for (genvar j = 0; j < NCH; j++) begin : g_peer
            assign peerHit[j] = doneVec[j] & restart_ff[j][i];
        end
        assign startVec[i] = startWr[i] | (|peerHit);

        pte_channel #(
            .DIVW (DIVW)
        ) u_channel (
            .ref_clk  (ref_clk),
            .resetn   (resetn),
            .chEnable (enable_ff[i]),
            .chStart  (startVec[i]),
            .chCfg    (cfg_ff[i]),
            .pulseOut (chOut[i]),
            .running  (runVec[i]),
            .loopDone (doneVec[i])
        );
    end

    // Output pin positions, registered inside the router
    pte_pin_route #(
        .NCH (NCH)
    ) u_route (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .chOut   (chOut),
        .altSel  (altSel_ff[NCH-1:0]),
        .funcEn  (funcEn_ff[NCH-1:0]),
        .pinAOut (pinAOut),
        .pinAEn  (pinAEn),
        .pinBOut (pinBOut),
        .pinBEn  (pinBEn)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_group_start: assert property (regWr && regAddr == `PTE_START_OFS |=>
                                    (16'(runVec) & $past(regWdata[15:0] & enable_ff)) ==
                                    $past(regWdata[15:0] & enable_ff))
        else $error("group start did not launch all selected generators");
    a_restart_chain: assert property (doneVec[0] && !regWr |=>
                                      (16'(runVec) & $past(restart_ff[0] & enable_ff)) ==
                                      $past(restart_ff[0] & enable_ff))
        else $error("end of loop count did not restart targets");
    a_read_latency: assert property (regRd && regAddr == `PTE_ENABLE_OFS |=>
                                     regRdata == {16'h0000, $past(enable_ff)} ##1 regRdata == '0 || $past(regRd))
        else $error("enable readback wrong");

    c_restart_seen: cover property (doneVec[0] && restart_ff[0] != 16'h0000);
    c_group_two: cover property (regWr && regAddr == `PTE_START_OFS && regWdata[1:0] == 2'h3);

endmodule : pulse_train_engine

/* sim/pte_pin_load.sv */
// Board side of the pins: each line has a weak pull-down, so a position that
// the engine does not drive reads 0 rather than the last driven level
module pte_pin_load (
    // Clock
    input  wire logic        ref_clk,
    // Pin positions from the engine
    input  wire logic [15:0] pinAOut,
    input  wire logic [15:0] pinAEn,
    input  wire logic [15:0] pinBOut,
    input  wire logic [15:0] pinBEn,
    // Resolved pad levels
    output logic      [15:0] padA,
    output logic      [15:0] padB
);
    timeunit 1ns;
    timeprecision 1ps;

    // Output-only pads, two positions per generator, pulled low when undriven
    always_comb begin
        padA = pinAOut & pinAEn;
        padB = pinBOut & pinBEn;
    end
endmodule : pte_pin_load

/* sim/test_pulse_train_engine.sv */
`include "pte_cfg.svh"

module test_pulse_train_engine;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk;
    logic        resetn;
    logic [9:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic [15:0] pinAOut;
    logic [15:0] pinAEn;
    logic [15:0] pinBOut;
    logic [15:0] pinBEn;
    logic [15:0] padA;
    logic [15:0] padB;
    int          errCount;
    int          checkCount;

    pulse_train_engine #(.NCH(16), .DIVW(16)) u_pulse_train_engine (
        .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinAOut(pinAOut),
        .pinAEn(pinAEn), .pinBOut(pinBOut), .pinBEn(pinBEn));

    pte_pin_load u_pte_pin_load (
        .ref_clk(ref_clk), .pinAOut(pinAOut), .pinAEn(pinAEn), .pinBOut(pinBOut),
        .pinBEn(pinBEn), .padA(padA), .padB(padB));

    // 20 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [9:0] chAddr(input int ch, input logic [1:0] idx);
        return {`PTE_CH_WIN_SEL, 4'(ch), idx, 2'b00};
    endfunction : chAddr

    // One-cycle write strobe, launched on a rising edge
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr

    // Read data are only valid in the cycle after the strobe edge
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        check(regRdata, exp);
    endtask : rd

    task automatic cfg(input int ch, mode, d, l, input logic [31:0] pat, input int loops);
        wr(chAddr(ch, `PTE_CH_LOOPS_IDX), 32'(loops));
        wr(chAddr(ch, `PTE_CH_PAT_IDX), pat);
        wr(chAddr(ch, `PTE_CH_CFG_IDX), 32'((mode << `PTE_CFG_MODE_LSB) | (d << `PTE_CFG_DIV_LSB) |
                                            (l << `PTE_CFG_LAST_LSB)));
    endtask : cfg

    // Start one generator alone and compare every pad, cycle by cycle, with the
    // waveform worked out from mode, divider, length and loop count; the pin
    // register lags the generator, so bit 0 shows from the first edge after start
    task automatic play(input int ch, mode, d, l, input logic [31:0] pat, input int loops, n,
                        input logic alt);
        int          el;
        int          t;
        int          idx;
        logic        bitv;
        logic [15:0] ev;
        el = (l < 1) ? 1 : l;
        t  = 1 << (d + 1);
        cfg(ch, mode, d, l, pat, loops);
        wr(`PTE_ENABLE_OFS, 32'(1 << ch));
        wr(`PTE_START_OFS, 32'(1 << ch));
        for (int k = 1; k <= n; k++) begin
            @(posedge ref_clk);
            #1;
            idx = (k - 1) / t;
            if (mode == 2) begin
                bitv = ((idx / (el + 1)) % 2) == 0;
            end else if ((mode == 1 && loops == 0) || idx < ((mode == 0) ? 1 : loops) * (el + 1)) begin
                bitv = pat[idx % (el + 1)];
            end else begin
                bitv = 1'b0;
            end
            ev = 16'(bitv) << ch;
            check(32'(alt ? padB : padA), 32'(ev));
            check(32'(alt ? padA : padB), 32'h0000_0000);
        end
        $display("test channel %0d mode %0d done", ch, mode);
    endtask : play

    task automatic printVerdict;
        $display("checks %0d, mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : printVerdict

    // Whole sequence needs about 480 cycles; allow 40,000 cycles
    initial begin
        #2_000_000;
        errCount++;
        printVerdict();
    end

    initial begin
        errCount   = 0;
        checkCount = 0;
        resetn     = 1'b0;
        regAddr    = 10'h000;
        regWdata   = 32'h0000_0000;
        regWr      = 1'b0;
        regRd      = 1'b0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        // Reset values, write-only and unmapped places
        rd(`PTE_ENABLE_OFS, 32'h0000_0000);
        rd(`PTE_PINSEL_OFS, 32'h0000_0000);
        rd(chAddr(0, `PTE_CH_CFG_IDX), 32'h0000_1f00);
        rd(chAddr(0, `PTE_CH_LOOPS_IDX), 32'h0000_0001);
        rd(`PTE_START_OFS, 32'h0000_0000);
        rd(10'h3fc, 32'h0000_0000);
        $display("test reset values done");
        // All generators routed out, channel 2 on its alternative position
        wr(`PTE_PINSEL_OFS, 32'hffff_0004);
        rd(`PTE_PINSEL_OFS, 32'hffff_0004);
        check(32'({pinBEn, pinAEn}), 32'h0004_fffb);
        play(0, 0, 0, 1, 32'h0000_0002, 1, 10, 1'b0);
        rd(`PTE_STATUS_OFS, 32'h0000_0000);
        play(1, 0, 1, 31, 32'h8000_00a5, 1, 140, 1'b0);
        play(2, 0, 0, 0, 32'h0000_0002, 1, 10, 1'b1);
        rd(chAddr(2, `PTE_CH_CFG_IDX), 32'h0000_0100);
        play(9, 1, 0, 2, 32'h0000_0005, 3, 24, 1'b0);
        play(10, 1, 2, 3, 32'h0000_0009, 0, 80, 1'b0);
        rd(`PTE_STATUS_OFS, 32'h0000_0400);
        play(11, 2, 1, 1, 32'h0000_0000, 1, 40, 1'b0);
        // Disable stops the square wave and drops the pin low
        wr(`PTE_ENABLE_OFS, 32'h0000_0000);
        repeat (3) @(posedge ref_clk);
        #1;
        check(32'(padA), 32'h0000_0000);
        rd(`PTE_STATUS_OFS, 32'h0000_0000);
        $display("test disable done");
        // Group start keeps two generators in step
        cfg(3, 1, 0, 2, 32'h0000_0006, 0);
        cfg(4, 1, 0, 2, 32'h0000_0006, 0);
        wr(`PTE_ENABLE_OFS, 32'h0000_0018);
        wr(`PTE_START_OFS, 32'h0000_0018);
        for (int k = 0; k < 12; k++) begin
            @(posedge ref_clk);
            #1;
            check(32'(padA[4]), 32'(padA[3]));
        end
        rd(`PTE_STATUS_OFS, 32'h0000_0018);
        $display("test group start done");
        // End of channel 0 restarts channel 6; channel 0 is the source the chain assertion watches
        wr(`PTE_ENABLE_OFS, 32'h0000_0000);
        cfg(0, 0, 0, 1, 32'h0000_0003, 1);
        cfg(6, 0, 0, 1, 32'h0000_0001, 1);
        wr(chAddr(0, `PTE_CH_RSTRT_IDX), 32'h0000_0040);
        rd(chAddr(0, `PTE_CH_RSTRT_IDX), 32'h0000_0040);
        wr(`PTE_ENABLE_OFS, 32'h0000_0041);
        wr(`PTE_START_OFS, 32'h0000_0001);
        repeat (5) @(posedge ref_clk);
        rd(`PTE_STATUS_OFS, 32'h0000_0040);
        check(32'(padA), 32'h0000_0040);
        repeat (10) @(posedge ref_clk);
        // Start of a generator that is not enabled is ignored
        wr(`PTE_START_OFS, 32'h0000_0080);
        rd(`PTE_STATUS_OFS, 32'h0000_0000);
        $display("test restart and refused start done");
        printVerdict();
    end
endmodule : test_pulse_train_engine
